/* hw/adc_result_window_regs.sv */
/*
 * Register-side logic of the converter: result formatting and low-byte
 * latch, sampling-time control, upper-window interrupt.
 * Assumes a one-cycle strobe register port, a converter core that pulses
 * result_valid with a 12- or 14-bit right-aligned result, and a one-cycle
 * tick per converter clock.
 */
// Overview of operation
// - Reading the high result byte latches the matching low byte.
// - Low result register is read-only and resets to zero.
// - Left, 12-bit: four low result bits in low bits 7:4.
// - Left, 14-bit: six low result bits in low bits 7:2.
// - Right alignment: eight low result bits fill the low register.
// - Sampling duration applies to software and event-started conversions.
// - Sampling code decodes to 2 up to 1024 converter clocks.
// - Sampling bits 3:0 read zero, are read-only; software writes zero.
// - Window interrupt when result strictly exceeds the upper limit.
// - Upper limit high byte is read/write, resets to FFh.
// - Left alignment: eight result MSBs against whole high byte.
// - Right, 12-bit: four MSBs against high bits 3:0.
// - Right, 14-bit: six MSBs against high bits 5:0.
// - Upper limit low byte is read/write, resets to FFh.
// - Left, 12-bit: four LSBs against low bits 7:4.
// - Left, 14-bit: six LSBs against low bits 7:2.
// - Right alignment: eight LSBs against whole low byte.

`timescale 1ns/1ps
`default_nettype none
`include "adc_window_regs.svh"
module adc_result_window_regs
	import adc_window_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Register port
	input wire logic [11:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	// Converter core
	input wire logic conv_clock_tick,
	input wire logic event_trigger,
	input wire logic result_valid,
	input wire logic [13:0] result_data,
	output logic conversion_start,
	output logic sampling_active,
	output logic sample_done,
	output logic bit_depth_select,
	// Interrupt
	output logic irq
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	align_type align_q, align_d;
	depth_type depth_q, depth_d;
	logic busy_q, busy_d;
	logic start_q, start_d;
	logic [13:0] result_q, result_d;
	logic [7:0] result_low_q, result_low_d;
	logic [3:0] sampling_code_q, sampling_code_d;
	logic [7:0] upper_limit_high_q, upper_limit_high_d;
	logic [7:0] upper_limit_low_q, upper_limit_low_d;
	logic [1:0] status_q, status_d;
	logic [1:0] mask_q, mask_d;
	logic [7:0] rdata_q, rdata_d;

	logic wr_control;
	logic wr_status;
	logic start_req;
	logic [7:0] fmt_high;
	logic [7:0] fmt_low;
	logic [1:0] events;

	conv_if link ();

	// ----------------------------------------------------------------
	// Submodules
	// ----------------------------------------------------------------
	sample_timer timer_inst (
		.clock(clock),
		.rst_n(rst_n),
		.bus(link.timer)
	);

	window_compare compare_inst (
		.bus(link.cmp)
	);

	assign link.start = start_req;
	assign link.code = sampling_code_q;
	assign link.tick = conv_clock_tick;
	// Compare the incoming result with the limits in force right now
	assign link.result = result_data;
	assign link.limit_high = upper_limit_high_q;
	assign link.limit_low = upper_limit_low_q;
	assign link.align = align_q;
	assign link.depth = depth_q;

	// ----------------------------------------------------------------
	// Conversion start
	// ----------------------------------------------------------------
	assign wr_control = reg_write && (reg_addr == `ADDR_CONTROL);
	assign wr_status = reg_write && (reg_addr == `ADDR_STATUS);

	// A start while busy is dropped; the core cannot take two at once
	always_comb begin
		start_req = 1'b0;
		if (!busy_q) begin
			if (wr_control && (reg_wdata[`CTRL_START_F] == `START_CONVERT)) begin
				start_req = 1'b1;
			end
			if (event_trigger) begin
				start_req = 1'b1;
			end
		end
	end

	always_comb begin
		align_d = align_q;
		depth_d = depth_q;
		busy_d = busy_q;
		start_d = start_req;
		if (wr_control) begin
			align_d = reg_wdata[`CTRL_ALIGN_BIT] ? ALIGN_RIGHT : ALIGN_LEFT;
			depth_d = reg_wdata[`CTRL_DEPTH_BIT] ? DEPTH_14 : DEPTH_12;
		end
		if (start_req) begin
			busy_d = 1'b1;
		end else if (result_valid) begin
			busy_d = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			align_q <= ALIGN_LEFT;
			depth_q <= DEPTH_12;
			busy_q <= `CTRL_RESET;
			start_q <= `CTRL_RESET;
		end else begin
			align_q <= align_d;
			depth_q <= depth_d;
			busy_q <= busy_d;
			start_q <= start_d;
		end
	end

	// ----------------------------------------------------------------
	// Result formatting
	// ----------------------------------------------------------------
	always_comb begin
		fmt_high = 8'h00;
		fmt_low = 8'h00;
		unique case ({align_q, depth_q})
			{ALIGN_LEFT, DEPTH_12}: begin
				fmt_high = result_q[11:4];
				fmt_low = {result_q[3:0], 4'h0};
			end
			{ALIGN_LEFT, DEPTH_14}: begin
				fmt_high = result_q[13:6];
				fmt_low = {result_q[5:0], 2'h0};
			end
			{ALIGN_RIGHT, DEPTH_12}: begin
				fmt_high = {4'h0, result_q[11:8]};
				fmt_low = result_q[7:0];
			end
			{ALIGN_RIGHT, DEPTH_14}: begin
				fmt_high = {2'h0, result_q[13:8]};
				fmt_low = result_q[7:0];
			end
		endcase
	end

	// Low byte only moves on a high-byte read, so a pair always matches
	always_comb begin
		result_d = result_q;
		result_low_d = result_low_q;
		if (result_valid) begin
			result_d = result_data;
		end
		if (reg_read && (reg_addr == `ADDR_RESULT_HIGH)) begin
			result_low_d = fmt_low;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			result_q <= `RESULT_RESET;
			result_low_q <= `RESULT_LOW_RESET;
		end else begin
			result_q <= result_d;
			result_low_q <= result_low_d;
		end
	end

	// ----------------------------------------------------------------
	// Sampling and limit registers
	// ----------------------------------------------------------------
	always_comb begin
		sampling_code_d = sampling_code_q;
		upper_limit_high_d = upper_limit_high_q;
		upper_limit_low_d = upper_limit_low_q;
		if (reg_write) begin
			unique case (reg_addr)
				`ADDR_SAMPLING: sampling_code_d = reg_wdata[`SAMPLING_CODE_F];
				`ADDR_LIMIT_HIGH: upper_limit_high_d = reg_wdata;
				`ADDR_LIMIT_LOW: upper_limit_low_d = reg_wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sampling_code_q <= `SAMPLING_RESET;
			upper_limit_high_q <= `LIMIT_RESET;
			upper_limit_low_q <= `LIMIT_RESET;
		end else begin
			sampling_code_q <= sampling_code_d;
			upper_limit_high_q <= upper_limit_high_d;
			upper_limit_low_q <= upper_limit_low_d;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt status and mask
	// ----------------------------------------------------------------
	always_comb begin
		events = 2'h0;
		events[`STAT_ABOVE_BIT] = result_valid && link.above;
		events[`STAT_DONE_BIT] = result_valid;
	end

	// Set beats a write-one-to-clear in the same cycle
	always_comb begin
		status_d = status_q;
		mask_d = mask_q;
		if (wr_status) begin
			status_d = status_q & ~reg_wdata[`STAT_F];
		end
		status_d = status_d | events;
		if (reg_write && (reg_addr == `ADDR_MASK)) begin
			mask_d = reg_wdata[`STAT_F];
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			status_q <= `STAT_RESET;
			mask_q <= `STAT_RESET;
		end else begin
			status_q <= status_d;
			mask_q <= mask_d;
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// Data stands only in the cycle after the read strobe
	always_comb begin
		rdata_d = `READ_IDLE;
		if (reg_read) begin
			unique case (reg_addr)
				`ADDR_CONTROL: begin
					rdata_d[`CTRL_ALIGN_BIT] = (align_q == ALIGN_RIGHT);
					rdata_d[`CTRL_DEPTH_BIT] = (depth_q == DEPTH_14);
					rdata_d[`CTRL_BUSY_BIT] = busy_q;
				end
				`ADDR_STATUS: rdata_d[`STAT_F] = status_q;
				`ADDR_MASK: rdata_d[`STAT_F] = mask_q;
				`ADDR_RESULT_HIGH: rdata_d = fmt_high;
				`ADDR_RESULT_LOW: rdata_d = result_low_q;
				`ADDR_SAMPLING: rdata_d[`SAMPLING_CODE_F] = sampling_code_q;
				`ADDR_LIMIT_HIGH: rdata_d = upper_limit_high_q;
				`ADDR_LIMIT_LOW: rdata_d = upper_limit_low_q;
				default: rdata_d = `READ_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= `READ_IDLE;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign reg_rdata = rdata_q;
	assign conversion_start = start_q;
	assign sampling_active = link.sampling;
	assign sample_done = link.sample_done;
	assign bit_depth_select = (depth_q == DEPTH_14);
	assign irq = |(status_q & mask_q);
endmodule
`default_nettype wire

/* hw/adc_window_pkg.sv */
/*
 * Types shared by the result/window register block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package adc_window_pkg;
	typedef enum logic {ALIGN_LEFT, ALIGN_RIGHT} align_type;
	typedef enum logic {DEPTH_12, DEPTH_14} depth_type;
	typedef enum logic {TIMER_IDLE, TIMER_SAMPLING} sample_state_type;
endpackage

/* hw/adc_window_regs.svh */
/*
 * Register offsets, field ranges, reset values and the sampling table
 * of the converter result/window register block.
 * Assumes byte-wide registers on a 12-bit register port address.
 */
`ifndef ADC_WINDOW_REGS_SVH
`define ADC_WINDOW_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_CONTROL 12'hF70
`define ADDR_STATUS 12'hF71
`define ADDR_MASK 12'hF72
`define ADDR_RESULT_HIGH 12'hF76
`define ADDR_RESULT_LOW 12'hF77
`define ADDR_SAMPLING 12'hF78
`define ADDR_LIMIT_HIGH 12'hF79
`define ADDR_LIMIT_LOW 12'hF7A

// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define CTRL_START_F 1:0
`define CTRL_ALIGN_BIT 2
`define CTRL_DEPTH_BIT 3
`define CTRL_BUSY_BIT 7
`define START_CONVERT 2'h1
`define SAMPLING_CODE_F 7:4
`define STAT_ABOVE_BIT 0
`define STAT_DONE_BIT 1
`define STAT_F 1:0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RESULT_LOW_RESET 8'h00
`define SAMPLING_RESET 4'h0
`define LIMIT_RESET 8'hFF
`define CTRL_RESET 1'h0
`define STAT_RESET 2'h0
`define RESULT_RESET 14'h0000
`define READ_IDLE 8'h00

// ----------------------------------------------------------------
// Sampling converter clocks, index is the sampling code
// ----------------------------------------------------------------
`define SAMPLING_TABLE '{11'h002, 11'h002, 11'h004, 11'h008, \
	11'h010, 11'h020, 11'h040, 11'h060, 11'h080, 11'h0C0, \
	11'h100, 11'h140, 11'h180, 11'h200, 11'h300, 11'h400}
`define COUNT_LAST 11'h001
`define COUNT_IDLE 11'h000

`endif

/* hw/conv_if.sv */
/*
 * Internal carrier between the register top, the sampling timer and
 * the window comparator. Assumes one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
interface conv_if;
	import adc_window_pkg::*;
	logic start;
	logic [3:0] code;
	logic tick;
	logic sampling;
	logic sample_done;
	logic [13:0] result;
	logic [7:0] limit_high;
	logic [7:0] limit_low;
	align_type align;
	depth_type depth;
	logic above;
	modport timer (input start, code, tick, output sampling, sample_done);
	modport timer_ctl (output start, code, tick, input sampling, sample_done);
	modport cmp (input result, limit_high, limit_low, align, depth, output above);
	modport cmp_ctl (output result, limit_high, limit_low, align, depth, input above);
endinterface
`default_nettype wire

/* hw/sample_timer.sv */
/*
 * Sampling-duration timer: decodes the sampling code and counts
 * converter-clock ticks after each conversion start.
 * Assumes tick is a one-cycle pulse per converter clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "adc_window_regs.svh"
module sample_timer
	import adc_window_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Control side
	conv_if.timer bus
);
	localparam logic [10:0] clocks_table [0:15] = `SAMPLING_TABLE;

	sample_state_type state_q, state_d;
	logic [10:0] count_q, count_d;

	// Code latched at start; later code writes affect the next conversion
	always_comb begin
		state_d = state_q;
		count_d = count_q;
		bus.sample_done = 1'b0;
		unique case (state_q)
			TIMER_IDLE: begin
				if (bus.start) begin
					state_d = TIMER_SAMPLING;
					count_d = clocks_table[bus.code];
				end
			end
			TIMER_SAMPLING: begin
				if (bus.tick) begin
					if (count_q == `COUNT_LAST) begin
						bus.sample_done = 1'b1;
						state_d = TIMER_IDLE;
						count_d = `COUNT_IDLE;
					end else begin
						count_d = count_q - `COUNT_LAST;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= TIMER_IDLE;
			count_q <= `COUNT_IDLE;
		end else begin
			state_q <= state_d;
			count_q <= count_d;
		end
	end

	assign bus.sampling = (state_q == TIMER_SAMPLING);
endmodule
`default_nettype wire

/* hw/window_compare.sv */
/*
 * Upper-threshold comparator: joins the two limit bytes according to
 * alignment and depth and compares the unsigned result against them.
 * Assumes the result is right-aligned in its 14-bit carrier.
 */
`timescale 1ns/1ps
`default_nettype none
module window_compare
	import adc_window_pkg::*;
(
	conv_if.cmp bus
);
	logic [13:0] limit;

	always_comb begin
		limit = 14'h0000;
		unique case ({bus.align, bus.depth})
			{ALIGN_LEFT, DEPTH_12}: limit = {2'h0, bus.limit_high, bus.limit_low[7:4]};
			{ALIGN_LEFT, DEPTH_14}: limit = {bus.limit_high, bus.limit_low[7:2]};
			{ALIGN_RIGHT, DEPTH_12}: limit = {2'h0, bus.limit_high[3:0], bus.limit_low};
			{ALIGN_RIGHT, DEPTH_14}: limit = {bus.limit_high[5:0], bus.limit_low};
		endcase
	end

	// Strictly greater; equal to the limit is inside the window
	assign bus.above = (bus.result > limit);
endmodule
`default_nettype wire

/* testbench/adc_window_sva.sv */
/*
 * Port checker for the converter result/window register block.
 * Assumes the block's register map header and a single clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "adc_window_regs.svh"
module adc_window_sva (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Block ports
	input wire logic [11:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic conv_clock_tick,
	input wire logic event_trigger,
	input wire logic result_valid,
	input wire logic conversion_start,
	input wire logic sampling_active,
	input wire logic sample_done,
	input wire logic bit_depth_select,
	input wire logic irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// ------------------------------------------------
	// Tick count of the running sample window
	// ------------------------------------------------
	logic [10:0] ticks_q, ticks_d;
	logic legal, wr_start;
	assign wr_start = reg_write && reg_addr == `ADDR_CONTROL && reg_wdata[1:0] == `START_CONVERT;
	always_comb begin
		ticks_d = ticks_q;
		if (conversion_start)
			ticks_d = {10'h000, conv_clock_tick};
		else if (sampling_active && conv_clock_tick)
			ticks_d = ticks_q + 11'h001;
		// Current tick not yet in the count
		legal = (ticks_q + 11'h001) inside {11'h002, 11'h004, 11'h008, 11'h010, 11'h020,
			11'h040, 11'h060, 11'h080, 11'h0C0, 11'h100, 11'h140, 11'h180, 11'h200,
			11'h300, 11'h400};
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			ticks_q <= 11'h000;
		else
			ticks_q <= ticks_d;
	end
	// ------------------------------------------------
	// Properties
	// ------------------------------------------------
	sequence s_open;
		conversion_start ##0 sampling_active;
	endsequence
	sequence s_close;
		sample_done ##1 !sampling_active;
	endsequence
	property p_start_opens;
		conversion_start |-> s_open;
	endproperty
	a_start_opens: assert property (p_start_opens) else $error("start without sampling");
	property p_start_cause;
		conversion_start |-> $past(event_trigger) || $past(wr_start);
	endproperty
	a_start_cause: assert property (p_start_cause) else $error("start without request");
	property p_no_restart;
		conversion_start |-> !$past(sampling_active);
	endproperty
	a_no_restart: assert property (p_no_restart) else $error("start while sampling");
	property p_close;
		sample_done |-> s_close;
	endproperty
	a_close: assert property (p_close) else $error("sampling kept after done");
	property p_done_on_tick;
		sample_done |-> conv_clock_tick && sampling_active;
	endproperty
	a_done_on_tick: assert property (p_done_on_tick) else $error("done off tick");
	property p_count;
		sample_done |-> legal;
	endproperty
	a_count: assert property (p_count) else $error("sampling tick count illegal");
	property p_depth;
		reg_write && reg_addr == `ADDR_CONTROL |=> bit_depth_select == $past(reg_wdata[3]);
	endproperty
	a_depth: assert property (p_depth) else $error("depth not taken");
	property p_samp_low;
		reg_read && reg_addr == `ADDR_SAMPLING |=> reg_rdata[3:0] == 4'h0;
	endproperty
	a_samp_low: assert property (p_samp_low) else $error("sampling low bits set");
	property p_irq_hold;
		irq && !reg_write |=> irq;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq dropped alone");
endmodule
bind adc_result_window_regs adc_window_sva chk_u (
	.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.conv_clock_tick(conv_clock_tick), .event_trigger(event_trigger),
	.result_valid(result_valid), .conversion_start(conversion_start),
	.sampling_active(sampling_active), .sample_done(sample_done),
	.bit_depth_select(bit_depth_select), .irq(irq)
);
`default_nettype wire

/* testbench/conv_core_model.sv */
/*
 * Behavioural analog core: free-running converter ticks and a result
 * some cycles after sampling ends. Assumes one clock.
 */
`timescale 1ns/1ps
`default_nettype none
module conv_core_model (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Block side
	input wire logic sample_done,
	input wire logic [3:0] tick_gap,
	input wire logic [13:0] next_result,
	output logic conv_clock_tick,
	output logic result_valid,
	output logic [13:0] result_data
);
	logic [3:0] gap_q;
	logic [2:0] wait_q;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			gap_q <= 4'h0;
			wait_q <= 3'h0;
			conv_clock_tick <= 1'b0;
			result_valid <= 1'b0;
			result_data <= 14'h0000;
		end else begin
			conv_clock_tick <= gap_q == tick_gap;
			gap_q <= (gap_q == tick_gap) ? 4'h0 : gap_q + 4'h1;
			wait_q <= sample_done ? 3'h6 : (wait_q != 3'h0) ? wait_q - 3'h1 : 3'h0;
			result_valid <= wait_q == 3'h1;
			// Stale data toggles so nothing reads it by luck
			result_data <= (wait_q == 3'h1) ? next_result : ~result_data;
		end
	end
endmodule
`default_nettype wire

/* testbench/tb_adc_result_window_regs.sv */
/*
 * Self-checking bench of the result/window register block.
 * Assumes the register map header and the analog core model.
 */
`timescale 1ns/1ps
`default_nettype none
`include "adc_window_regs.svh"
module tb_adc_result_window_regs;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [11:0] reg_addr = 12'h000;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic event_trigger = 1'b0;
	logic [3:0] tick_gap = 4'h0;
	logic [13:0] next_result = 14'h0000;
	logic [7:0] reg_rdata;
	logic [13:0] result_data;
	logic conv_clock_tick, result_valid, conversion_start, sampling_active;
	logic sample_done, bit_depth_select, irq;
	logic rd_pend = 1'b0;
	logic [7:0] rd_q [$];
	logic [15:0] n_q [$];
	logic [15:0] nt = 16'h0000, starts = 16'h0000, nconv = 16'h0000;
	logic [3:0] cur_code = 4'h0;
	logic [15:0] tbl [16] = '{16'h0002, 16'h0002, 16'h0004, 16'h0008, 16'h0010, 16'h0020,
		16'h0040, 16'h0060, 16'h0080, 16'h00C0, 16'h0100, 16'h0140, 16'h0180, 16'h0200,
		16'h0300, 16'h0400};
	int miscompares = 0;
	int comparisons = 0;
	int cycles = 0;
	always #2 clock = ~clock;
	adc_result_window_regs dut_u (
		.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.conv_clock_tick(conv_clock_tick), .event_trigger(event_trigger),
		.result_valid(result_valid), .result_data(result_data),
		.conversion_start(conversion_start), .sampling_active(sampling_active),
		.sample_done(sample_done), .bit_depth_select(bit_depth_select), .irq(irq)
	);
	conv_core_model core_u (
		.clock(clock), .rst_n(rst_n), .sample_done(sample_done), .tick_gap(tick_gap),
		.next_result(next_result), .conv_clock_tick(conv_clock_tick),
		.result_valid(result_valid), .result_data(result_data)
	);
	// ------------------------------------------------
	// Tasks
	// ------------------------------------------------
	task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic wr(logic [11:0] a, logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	task automatic rd(logic [11:0] a, logic [7:0] e);
		rd_q.push_back(e);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
	endtask
	// Left alignment shifts the value to the top of the byte pair
	function automatic logic [15:0] place(logic al, logic dp, logic [13:0] v);
		place = al ? {2'h0, v} : {2'h0, v} << (dp ? 2 : 4);
	endfunction
	// Second event pulse lands while busy and must be dropped
	task automatic conv(logic al, logic dp, logic ev, logic [13:0] r);
		int k;
		k = 0;
		next_result <= r;
		n_q.push_back(tbl[cur_code]);
		nconv++;
		wr(`ADDR_CONTROL, {4'h0, dp, al, 1'b0, !ev});
		@(posedge clock);
		event_trigger <= ev;
		@(posedge clock);
		event_trigger <= 1'b1;
		@(posedge clock);
		event_trigger <= 1'b0;
		while (!result_valid && k < 3000) begin
			@(posedge clock);
			#1;
			k++;
		end
		if (!result_valid)
			chk("result_valid", 16'h0000, 16'h0001);
		@(posedge clock);
	endtask
	// ------------------------------------------------
	// Output monitor and timeout
	// ------------------------------------------------
	always @(posedge clock) begin
		cycles++;
		if (rd_pend)
			chk("reg_rdata", {8'h00, reg_rdata}, {8'h00, rd_q.pop_front()});
		rd_pend = reg_read;
		if (conversion_start)
			starts++;
		if (sampling_active && conv_clock_tick)
			nt++;
		if (sample_done) begin
			chk("ticks", nt, n_q.pop_front());
			nt = 16'h0000;
		end
		if (cycles == 30000) begin
			miscompares++;
			give_verdict;
		end
	end
	// ------------------------------------------------
	// Main sequence
	// ------------------------------------------------
	initial begin
		logic [7:0] v;
		logic [13:0] thr, mx, r;
		logic [15:0] t, last_low;
		logic al, dp;
		v = 8'($urandom(63));
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		rd(`ADDR_RESULT_LOW, 8'h00);
		rd(`ADDR_SAMPLING, 8'h00);
		rd(`ADDR_LIMIT_HIGH, 8'hFF);
		rd(`ADDR_LIMIT_LOW, 8'hFF);
		rd(12'hF7F, 8'h00);
		v = 8'($urandom);
		wr(`ADDR_LIMIT_HIGH, v);
		wr(`ADDR_LIMIT_LOW, {~v[7:4], 4'h0});
		wr(`ADDR_RESULT_LOW, 8'hA5);
		wr(`ADDR_SAMPLING, {v[7:4], 4'h0});
		rd(`ADDR_LIMIT_HIGH, v);
		rd(`ADDR_LIMIT_LOW, {~v[7:4], 4'h0});
		rd(`ADDR_RESULT_LOW, 8'h00);
		rd(`ADDR_SAMPLING, {v[7:4], 4'h0});
		$display("test registers done");
		for (int c = 0; c < 16; c++) begin
			cur_code = c[3:0];
			wr(`ADDR_SAMPLING, {cur_code, 4'h0});
			tick_gap <= {3'h0, c[0]};
			conv(1'b0, 1'b0, c[0], 14'($urandom) & 14'h0FFF);
		end
		$display("test sampling done");
		cur_code = 4'h0;
		wr(`ADDR_SAMPLING, 8'h00);
		wr(`ADDR_STATUS, 8'h03);
		last_low = 16'h0000;
		for (int md = 0; md < 4; md++) begin
			al = md[1];
			dp = md[0];
			mx = dp ? 14'h3FFF : 14'h0FFF;
			thr = 14'($urandom) & mx;
			if (thr == mx)
				thr = thr - 14'h0001;
			t = place(al, dp, thr);
			wr(`ADDR_LIMIT_HIGH, t[15:8]);
			wr(`ADDR_LIMIT_LOW, t[7:0]);
			wr(`ADDR_MASK, {7'h00, md != 2});
			for (int j = 0; j < 3; j++) begin
				r = (j == 2) ? 14'($urandom) & mx : thr + 14'(j);
				rd(`ADDR_RESULT_LOW, last_low[7:0]);
				conv(al, dp, j[0], r);
				rd(`ADDR_STATUS, {6'h00, 1'b1, r > thr});
				#1;
				chk("irq", {15'h0000, irq}, {15'h0000, r > thr && md != 2});
				t = place(al, dp, r);
				rd(`ADDR_RESULT_HIGH, t[15:8]);
				rd(`ADDR_RESULT_LOW, t[7:0]);
				last_low = t;
				wr(`ADDR_STATUS, 8'h03);
			end
		end
		chk("starts", starts, nconv);
		$display("test window done");
		give_verdict;
	end
endmodule
`default_nettype wire
